/* core/i2c_seq_consts.svh */
`ifndef I2C_SEQ_CONSTS_SVH
`define I2C_SEQ_CONSTS_SVH
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define OFS_CTRL_ONE 8'h00
`define OFS_CTRL_TWO 8'h01
`define OFS_STATUS   8'h02
`define OFS_FLAGS    8'h03
`define OFS_XFER     8'h04
`define OFS_BAUD     8'h05
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define C1_PORT_EN   0
`define C1_IRQ_EN    1
`define C1_SLEEP     2
`define C2_START     0
`define C2_RSTART    1
`define C2_STOP      2
`define C2_ACK       4
`define C2_ACK_DATA_VALUE     5
`define C2_ACKSTAT   6
`define ST_BF        0
`define ST_START     3
`define ST_STOP      4
`define FL_IRQ       0
`define FL_BCL       1
`define FL_WRITE_COLLISION_FLAG      2
// ---------------------------------------------------------------
// reset values and counts
// ---------------------------------------------------------------
`define RST_BYTE     8'h00
`define RST_BAUD     7'h09
`define LAST_BIT     4'h8
`endif

/* core/i2c_seq_master.sv */
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "i2c_seq_consts.svh"

module i2c_seq_master
    import i2c_seq_pkg::*;
#(
    parameter int BAUD_W = 7
) (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // bus wires
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            scl_out,
    output logic            scl_oe,
    output logic            sda_out,
    output logic            sda_oe,
    // wake request
    output logic            wake_req
);
    // ---------------------------------------------------------------
    // parameter check
    // ---------------------------------------------------------------
    if (BAUD_W < 1 || BAUD_W > 8) begin : g_bad_width
        $error("BAUD_W must lie in 1..8");
    end

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    seq_state_e        state_ff, nxt_state;
    logic [1:0]        scl_sync_ff, sda_sync_ff;
    line_s             prev_ff, bus, drv_ff, nxt_drv;
    logic [2:0]        ctrl1_ff;
    logic [3:0]        en_ff, nxt_en, clr_en;
    logic              ack_data_value_ff, ackstat_ff;
    logic [7:0]        xfer_ff, rdata_ff, rd_mux;
    logic [BAUD_W-1:0] baud_ff, cnt_ff, nxt_cnt;
    logic [3:0]        bit_ff, nxt_bit;
    logic              bf_ff, tx_req_ff, start_det_ff, stop_det_ff;
    logic              irq_ff, bcl_ff, write_collision_flag_ff, own_ff, hold_ff, watch_ff;
    logic              wake_ff, out_low_ff;
    logic              coll, seq_done, byte_done, ack_take, bf_clr;
    logic              nxt_own, nxt_hold;

    // ---------------------------------------------------------------
    // decode
    // ---------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // released or pulled wire must reach its level before the baud count may run
    function automatic logic wait_ok(input seq_state_e s, input line_s b);
        unique case (s)
            S_RS_RISE, S_TX_HIGH, S_AK_HIGH, S_SP_SCLH: wait_ok = b.scl;
            S_SP_LOW:  wait_ok = ~b.sda;
            S_SP_SDAH: wait_ok = b.sda & b.scl;
            default:   wait_ok = 1'b1;
        endcase
    endfunction : wait_ok

    function automatic line_s drive(input seq_state_e s, input logic txb,
                                    input logic ack_data_value, input logic own,
                                    input logic hold);
        line_s d;
        d = '{scl: 1'b0, sda: 1'b0};
        unique case (s)
            S_IDLE:    d = '{scl: own, sda: hold};
            S_ST_LOW:  d.sda = 1'b1;
            S_RS_LOW:  d.scl = 1'b1;
            S_RS_SDA:  d.sda = 1'b1;
            S_TX_LOW:  d = '{scl: 1'b1, sda: ~txb};
            S_TX_HIGH: d.sda = ~txb;
            S_AK_LOW:  d = '{scl: 1'b1, sda: ~ack_data_value};
            S_AK_HIGH: d.sda = ~ack_data_value;
            S_SP_LOW:  d = '{scl: 1'b1, sda: 1'b1};
            S_SP_SCLH: d.sda = 1'b1;
            default:   d = '{scl: 1'b0, sda: 1'b0};
        endcase
        drive = d;
    endfunction : drive

    wire wr_c1   = reg_wr & hit(reg_addr, `OFS_CTRL_ONE);
    wire wr_c2   = reg_wr & hit(reg_addr, `OFS_CTRL_TWO);
    wire wr_fl   = reg_wr & hit(reg_addr, `OFS_FLAGS);
    wire wr_xf   = reg_wr & hit(reg_addr, `OFS_XFER);
    wire wr_bd   = reg_wr & hit(reg_addr, `OFS_BAUD);
    wire port_en = ctrl1_ff[`C1_PORT_EN];
    wire busy    = (state_ff != S_IDLE) | (|en_ff) | tx_req_ff;
    wire cmd_ok  = wr_c2 & ~busy & port_en;
    wire xf_ok   = wr_xf & ~busy;
    wire write_collision_flag_set = wr_xf & busy;
    wire [3:0] cmd_bits = {reg_wdata[`C2_ACK], reg_wdata[`C2_STOP],
                           reg_wdata[`C2_RSTART], reg_wdata[`C2_START]};

    assign bus = '{scl: scl_sync_ff[1], sda: sda_sync_ff[1]};
    wire start_edge = prev_ff.sda & ~bus.sda & bus.scl & prev_ff.scl;
    wire stop_edge  = ~prev_ff.sda & bus.sda & bus.scl & prev_ff.scl;
    wire tx_bit  = bit_ff[3] ? 1'b1 : xfer_ff[~bit_ff[2:0]];
    wire w_ok    = wait_ok(state_ff, bus);
    wire tick    = w_ok & (cnt_ff == '0);
    wire load    = (nxt_state != state_ff) | ~w_ok | (state_ff == S_IDLE);
    assign nxt_cnt = load ? baud_ff : cnt_ff - 1'b1;

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        coll      = 1'b0;
        seq_done  = 1'b0;
        byte_done = 1'b0;
        ack_take  = 1'b0;
        bf_clr    = 1'b0;
        clr_en    = 4'h0;
        nxt_bit   = bit_ff;
        unique case (state_ff)
            S_IDLE: begin
                if (port_en) begin
                    if (en_ff[0]) nxt_state = S_ST_CHK;
                    else if (en_ff[1]) nxt_state = S_RS_LOW;
                    else if (en_ff[2]) nxt_state = S_SP_LOW;
                    else if (en_ff[3]) nxt_state = S_AK_LOW;
                    else if (tx_req_ff) begin
                        nxt_state = S_TX_LOW;
                        nxt_bit   = 4'h0;
                    end
                end
            end
            S_ST_CHK: begin
                if (~bus.sda | ~bus.scl) coll = 1'b1;
                else nxt_state = S_ST_HOLD;
            end
            S_ST_HOLD: begin
                if (~bus.scl & bus.sda) coll = 1'b1;
                else if (~bus.sda | tick) nxt_state = S_ST_LOW;
            end
            S_ST_LOW: begin
                if (tick) begin
                    nxt_state = S_IDLE;
                    seq_done  = 1'b1;
                    clr_en[0] = 1'b1;
                end
            end
            S_RS_LOW: if (tick) nxt_state = S_RS_RISE;
            S_RS_RISE: begin
                if (bus.scl) begin
                    if (~bus.sda) coll = 1'b1;
                    else nxt_state = S_RS_HIGH;
                end
            end
            S_RS_HIGH: begin
                if (~bus.scl & bus.sda) coll = 1'b1;
                else if (tick) nxt_state = S_RS_SDA;
            end
            S_RS_SDA: begin
                if (tick) begin
                    nxt_state = S_IDLE;
                    seq_done  = 1'b1;
                    clr_en[1] = 1'b1;
                end
            end
            S_TX_LOW: if (tick) nxt_state = S_TX_HIGH;
            S_TX_HIGH: begin
                if (bus.scl & tx_bit & ~bus.sda & ~bit_ff[3]) coll = 1'b1;
                else if (tick) begin
                    if (bit_ff == `LAST_BIT) begin
                        nxt_state = S_IDLE;
                        ack_take  = 1'b1;
                        seq_done  = 1'b1;
                        byte_done = 1'b1;
                    end else begin
                        nxt_state = S_TX_LOW;
                        nxt_bit   = bit_ff + 4'h1;
                        bf_clr    = (bit_ff == (`LAST_BIT - 4'h1));
                    end
                end
            end
            S_AK_LOW: if (tick) nxt_state = S_AK_HIGH;
            S_AK_HIGH: begin
                if (bus.scl & ack_data_value_ff & ~bus.sda) coll = 1'b1;
                else if (tick) begin
                    nxt_state = S_IDLE;
                    clr_en[3] = 1'b1;
                end
            end
            S_SP_LOW: if (tick) nxt_state = S_SP_SCLH;
            S_SP_SCLH: if (tick) nxt_state = S_SP_SDAH;
            S_SP_SDAH: begin
                if (tick) begin
                    nxt_state = S_IDLE;
                    seq_done  = 1'b1;
                    clr_en[2] = 1'b1;
                end
            end
            default: nxt_state = S_IDLE;
        endcase
        if (coll) begin
            nxt_state = S_IDLE;
            clr_en    = 4'hF;
        end
        if (~port_en) begin
            nxt_state = S_IDLE;
            clr_en    = 4'hF;
        end
    end

    assign nxt_en   = (cmd_ok ? cmd_bits : en_ff) & ~clr_en;
    assign nxt_own  = (coll | ~port_en | clr_en[2]) ? 1'b0 :
                      ((clr_en[0] | clr_en[1] | ack_take) ? 1'b1 : own_ff);
    assign nxt_hold = (coll | ~port_en) ? 1'b0 :
                      ((clr_en[0] | clr_en[1]) ? 1'b1 :
                      ((state_ff == S_IDLE && nxt_state != S_IDLE) ? 1'b0 : hold_ff));
    assign nxt_drv  = drive(nxt_state, tx_bit, ack_data_value_ff, nxt_own, nxt_hold);

    // ---------------------------------------------------------------
    // flip-flops
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_sync_ff <= 2'h3;
            sda_sync_ff <= 2'h3;
            prev_ff     <= '{scl: 1'b1, sda: 1'b1};
        end else begin
            scl_sync_ff <= {scl_sync_ff[0], scl_in};
            sda_sync_ff <= {sda_sync_ff[0], sda_in};
            prev_ff     <= bus;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= S_IDLE;
            cnt_ff   <= BAUD_W'(`RST_BAUD);
            bit_ff   <= 4'h0;
            en_ff    <= 4'h0;
            own_ff   <= 1'b0;
            hold_ff  <= 1'b0;
            drv_ff   <= '{scl: 1'b0, sda: 1'b0};
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            bit_ff   <= nxt_bit;
            en_ff    <= nxt_en;
            own_ff   <= nxt_own;
            hold_ff  <= nxt_hold;
            drv_ff   <= nxt_drv;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl1_ff   <= 3'h0;
            ack_data_value_ff   <= 1'b0;
            ackstat_ff <= 1'b0;
            baud_ff    <= BAUD_W'(`RST_BAUD);
            xfer_ff    <= `RST_BYTE;
        end else begin
            if (wr_c1) ctrl1_ff <= reg_wdata[2:0];
            if (wr_c2) ack_data_value_ff <= reg_wdata[`C2_ACK_DATA_VALUE];
            if (ack_take) ackstat_ff <= bus.sda;
            if (wr_bd) baud_ff <= reg_wdata[BAUD_W-1:0];
            if (xf_ok) xfer_ff <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bf_ff <= 1'b0;
            tx_req_ff <= 1'b0;
        end else begin
            bf_ff     <= xf_ok | (bf_ff & ~bf_clr & ~coll & port_en);
            tx_req_ff <= (xf_ok | tx_req_ff) & port_en & (state_ff != S_TX_LOW);
        end
    end

    // set wins over the write-one clear
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_ff   <= 1'b0;
            bcl_ff   <= 1'b0;
            write_collision_flag_ff  <= 1'b0;
            watch_ff <= 1'b0;
        end else begin
            irq_ff   <= seq_done | (watch_ff & stop_edge) |
                        (irq_ff & ~(wr_fl & reg_wdata[`FL_IRQ]));
            bcl_ff   <= coll | (bcl_ff & ~(wr_fl & reg_wdata[`FL_BCL]));
            write_collision_flag_ff  <= write_collision_flag_set | (write_collision_flag_ff & ~(wr_fl & reg_wdata[`FL_WRITE_COLLISION_FLAG]));
            watch_ff <= coll | (watch_ff & ~stop_edge);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            start_det_ff <= 1'b0;
            stop_det_ff  <= 1'b0;
        end else begin
            start_det_ff <= start_edge | (start_det_ff & ~stop_edge);
            stop_det_ff  <= stop_edge | (stop_det_ff & ~start_edge);
        end
    end

    // ---------------------------------------------------------------
    // read port and outputs
    // ---------------------------------------------------------------
    wire [7:0] c2_rd = {1'b0, ackstat_ff, ack_data_value_ff, en_ff[3], 1'b0, en_ff[2:0]};
    wire [7:0] st_rd = {3'h0, stop_det_ff, start_det_ff, 2'h0, bf_ff};
    wire [7:0] fl_rd = {5'h00, write_collision_flag_ff, bcl_ff, irq_ff};
    assign rd_mux = hit(reg_addr, `OFS_CTRL_ONE) ? {5'h00, ctrl1_ff} :
                    hit(reg_addr, `OFS_CTRL_TWO) ? c2_rd :
                    hit(reg_addr, `OFS_STATUS)   ? st_rd :
                    hit(reg_addr, `OFS_FLAGS)    ? fl_rd :
                    hit(reg_addr, `OFS_XFER)     ? xfer_ff :
                    hit(reg_addr, `OFS_BAUD)     ? 8'(baud_ff) : 8'h00;
    wire wake_now = ctrl1_ff[`C1_SLEEP] & ctrl1_ff[`C1_IRQ_EN] & byte_done;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff   <= 8'h00;
            wake_ff    <= 1'b0;
            out_low_ff <= 1'b0;
        end else begin
            rdata_ff   <= reg_rd ? rd_mux : 8'h00;
            wake_ff    <= wake_now;
            out_low_ff <= 1'b0;
        end
    end

    assign reg_rdata = rdata_ff;
    assign scl_oe    = drv_ff.scl;
    assign sda_oe    = drv_ff.sda;
    assign scl_out   = out_low_ff;
    assign sda_out   = out_low_ff;
    assign wake_req  = wake_ff;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_ack_drive_lines: assert property ((state_ff == S_AK_LOW) |->
        scl_oe && (sda_oe == ~ack_data_value_ff)) else $error("ack drive wrong");
    a_ack_seq_end: assert property ((state_ff == S_AK_HIGH && tick && !coll) |=>
        state_ff == S_IDLE && !en_ff[3]) else $error("ack end wrong");
    a_write_collision_flag_busy_write: assert property (wr_xf && busy |=>
        write_collision_flag_ff && $stable(xfer_ff)) else $error("busy write not refused");
    a_stop_seen_bit: assert property (stop_edge |=> stop_det_ff) else
        $error("stop not seen");
    a_stop_seq_end: assert property ((state_ff == S_SP_SDAH && tick) |=>
        irq_ff && !en_ff[2] && !scl_oe && !sda_oe) else $error("stop end wrong");
    a_scl_wait_reload: assert property ((state_ff == S_TX_HIGH && !bus.scl) |=>
        cnt_ff == baud_ff) else $error("baud not held");
    a_coll_release_all: assert property (coll |=>
        !scl_oe && !sda_oe && bcl_ff && !bf_ff && en_ff == 4'h0) else
        $error("collision not handled");
    a_start_low_abort: assert property ((state_ff == S_ST_CHK && !bus.scl) |=>
        state_ff == S_IDLE && bcl_ff) else $error("start abort missed");
    a_watch_stop_irq: assert property ((watch_ff && stop_edge) |=> irq_ff) else
        $error("stop after collision lost");

    c_ack_done: cover property (state_ff == S_AK_HIGH ##1 state_ff == S_IDLE);
    c_stop_done: cover property (state_ff == S_SP_SDAH ##1 state_ff == S_IDLE);
    c_tx_coll: cover property (state_ff == S_TX_HIGH && coll);
    c_rs_done: cover property (state_ff == S_RS_SDA ##1 state_ff == S_IDLE);
endmodule : i2c_seq_master

/* core/i2c_seq_pkg.sv */
package i2c_seq_pkg;
    typedef enum logic [3:0] {
        S_IDLE    = 4'h0,
        S_ST_CHK  = 4'h1,
        S_ST_HOLD = 4'h3,
        S_ST_LOW  = 4'h2,
        S_RS_LOW  = 4'h6,
        S_RS_RISE = 4'h7,
        S_RS_HIGH = 4'h5,
        S_RS_SDA  = 4'h4,
        S_TX_LOW  = 4'hC,
        S_TX_HIGH = 4'hD,
        S_AK_LOW  = 4'hF,
        S_AK_HIGH = 4'hE,
        S_SP_LOW  = 4'hA,
        S_SP_SCLH = 4'hB,
        S_SP_SDAH = 4'h9
    } seq_state_e;

    // one bit per wire: sampled level, or pull-low enable
    typedef struct packed {
        logic scl;
        logic sda;
    } line_s;
endpackage : i2c_seq_pkg

/* tb/i2c_bus_partner.sv */
`timescale 1ns/1ns

// -----------------------------------------------
// slave side: acks each byte, stretches scl, can hold sda low
// -----------------------------------------------
module i2c_bus_partner (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // wire levels and test controls
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic       sda_force,
    input  wire logic [7:0] stretch_n,
    // pull enables and captured byte
    output logic            scl_pull,
    output logic            sda_pull,
    output logic      [7:0] rx_byte
);
    logic       scl_q;
    logic       sda_q;
    logic       ack_pull;
    logic [3:0] rise_cnt;
    logic [7:0] hold_cnt;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_q    <= 1'b1;
            sda_q    <= 1'b1;
            ack_pull <= 1'b0;
            rise_cnt <= 4'h0;
            hold_cnt <= 8'h00;
            rx_byte  <= 8'h00;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (hold_cnt != 8'h00)
                hold_cnt <= hold_cnt - 8'h01;
            // start or stop on the bus restarts the bit count
            if (scl_q && scl && sda_q != sda) begin
                rise_cnt <= 4'h0;
                ack_pull <= 1'b0;
            end else if (!scl_q && scl) begin
                rise_cnt <= rise_cnt + 4'h1;
                if (rise_cnt < 4'h8)
                    rx_byte <= {rx_byte[6:0], sda};
            end else if (scl_q && !scl) begin
                hold_cnt <= stretch_n;
                if (rise_cnt == 4'h8)
                    ack_pull <= 1'b1;
                else if (rise_cnt == 4'h9) begin
                    ack_pull <= 1'b0;
                    rise_cnt <= 4'h0;
                end
            end
        end
    end

    assign scl_pull = hold_cnt != 8'h00;
    assign sda_pull = ack_pull | sda_force;
endmodule : i2c_bus_partner

/* tb/test_i2c_seq_master.sv */
`timescale 1ns/1ns
`include "i2c_seq_consts.svh"

module test_i2c_seq_master
    import i2c_seq_pkg::*;
;
    logic       core_clk  = 1'b0;
    logic       rst_n     = 1'b0;
    logic       reg_wr    = 1'b0;
    logic       reg_rd    = 1'b0;
    logic       sda_force = 1'b0;
    logic [7:0] reg_addr  = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] stretch_n = 8'h14;
    logic [7:0] min_high  = 8'hFF;
    logic [7:0] high_cnt  = 8'h00;
    logic [7:0] reg_rdata, rx_byte, d;
    logic       scl_out, scl_oe, sda_out, sda_oe, wake_req, scl_pull, sda_pull;
    int         err_count = 0;
    int         n_tests   = 0;
    int         wake_cnt  = 0;
    wire        scl = !(scl_oe | scl_pull);
    wire        sda = !(sda_oe | sda_pull);

    i2c_seq_master #(.BAUD_W(7)) i2c_seq_master_i (.core_clk, .rst_n, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .scl_in(scl), .sda_in(sda), .scl_out, .scl_oe,
        .sda_out, .sda_oe, .wake_req);
    i2c_bus_partner i2c_bus_partner_i (.core_clk, .rst_n, .scl, .sda, .sda_force,
        .stretch_n, .scl_pull, .sda_pull, .rx_byte);

    always #2 core_clk = ~core_clk;

    // -----------------------------------------------
    // monitors: wake pulses and shortest scl high time
    // -----------------------------------------------
    always @(posedge core_clk) begin
        wake_cnt <= wake_cnt + int'(wake_req);
        if (scl) begin
            if (high_cnt != 8'hFF)
                high_cnt <= high_cnt + 8'h01;
        end else begin
            if (high_cnt != 8'h00 && high_cnt < min_high)
                min_high <= high_cnt;
            high_cnt <= 8'h00;
        end
    end

    // -----------------------------------------------
    // register port tasks and compares
    // -----------------------------------------------
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task oe_chk(input logic [1:0] e);
        chk("scl_oe,sda_oe", {6'h00, e}, {6'h00, scl_oe, sda_oe});
    endtask : oe_chk

    task wait_bit(input logic [7:0] a, input int b, input logic v);
        int i;
        d = {8{~v}};
        for (i = 0; i < 3000 && d[b] !== v; i++)
            rd(a);
        chk("polled bit", {7'h00, v}, {7'h00, d[b]});
    endtask : wait_bit

    task open_bus;
        wr(`OFS_CTRL_TWO, 8'h01);
        wait_bit(`OFS_FLAGS, `FL_IRQ, 1'b1);
        wr(`OFS_FLAGS, 8'h07);
    endtask : open_bus

    task finish_test;
        if (err_count == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test

    initial begin
        repeat (60000) @(posedge core_clk);
        err_count++;
        finish_test();
    end

    // -----------------------------------------------
    // test sequence
    // -----------------------------------------------
    initial begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(`OFS_CTRL_TWO);
        chk("ctrl_two reset", 8'h00, d);
        rd(`OFS_BAUD);
        chk("baud reset", 8'h09, d);
        chk("line data", 8'h00, {6'h00, scl_out, sda_out});
        wr(`OFS_BAUD, 8'h0E);
        wr(`OFS_CTRL_ONE, 8'h03);
        open_bus();
        wr(`OFS_XFER, 8'hA5);
        wr(`OFS_XFER, 8'h3C);
        rd(`OFS_STATUS);
        chk("buffer full", 8'h01, d & 8'h01);
        wait_bit(`OFS_FLAGS, `FL_IRQ, 1'b1);
        chk("byte on wire", 8'hA5, rx_byte);
        wr(`OFS_FLAGS, 8'h07);
        wr(`OFS_CTRL_TWO, 8'h10);
        @(posedge core_clk);
        #1 oe_chk(2'b11);
        wr(`OFS_XFER, 8'h11);
        wait_bit(`OFS_CTRL_TWO, `C2_ACK, 1'b0);
        oe_chk(2'b10);
        rd(`OFS_FLAGS);
        chk("flags after ack", 8'h04, d);
        rd(`OFS_XFER);
        chk("buffer kept", 8'hA5, d);
        rd(`OFS_FLAGS);
        chk("write_collision_flag kept", 8'h04, d);
        wr(`OFS_FLAGS, 8'h04);
        wr(`OFS_CTRL_TWO, 8'h04);
        @(posedge core_clk);
        #1 chk("sda_oe stop", 8'h01, {7'h00, sda_oe});
        wr(`OFS_XFER, 8'h22);
        wait_bit(`OFS_FLAGS, `FL_IRQ, 1'b1);
        chk("write_collision_flag in stop", 8'h04, d & 8'h04);
        rd(`OFS_STATUS);
        chk("stop seen", 8'h10, d & 8'h10);
        rd(`OFS_CTRL_TWO);
        chk("stop enable", 8'h00, d & 8'h04);
        oe_chk(2'b00);
        wr(`OFS_FLAGS, 8'h07);
        wr(`OFS_CTRL_ONE, 8'h07);
        open_bus();
        wr(`OFS_XFER, 8'h80);
        wait_bit(`OFS_FLAGS, `FL_IRQ, 1'b1);
        chk("wake count", 8'h01, 8'(wake_cnt));
        wr(`OFS_FLAGS, 8'h07);
        wr(`OFS_XFER, 8'hFF);
        repeat (40) @(posedge core_clk);
        sda_force <= 1'b1;
        wait_bit(`OFS_FLAGS, `FL_BCL, 1'b1);
        rd(`OFS_STATUS);
        chk("bf after collision", 8'h00, d & 8'h01);
        oe_chk(2'b00);
        repeat (30) @(posedge core_clk);
        sda_force <= 1'b0;
        wait_bit(`OFS_FLAGS, `FL_IRQ, 1'b1);
        wr(`OFS_FLAGS, 8'h07);
        wr(`OFS_XFER, 8'hC3);
        wait_bit(`OFS_FLAGS, `FL_IRQ, 1'b1);
        chk("byte after collision", 8'hC3, rx_byte);
        wr(`OFS_FLAGS, 8'h07);
        sda_force <= 1'b1;
        wr(`OFS_CTRL_TWO, 8'h01);
        wait_bit(`OFS_FLAGS, `FL_BCL, 1'b1);
        rd(`OFS_CTRL_TWO);
        chk("start enable", 8'h00, d & 8'h01);
        oe_chk(2'b00);
        sda_force <= 1'b0;
        repeat (40) @(posedge core_clk);
        wr(`OFS_FLAGS, 8'h07);
        open_bus();
        wr(`OFS_CTRL_TWO, 8'h02);
        wait_bit(`OFS_FLAGS, `FL_IRQ, 1'b1);
        oe_chk(2'b11);
        rd(`OFS_STATUS);
        chk("start seen", 8'h08, d & 8'h08);
        wr(`OFS_FLAGS, 8'h07);
        wr(`OFS_XFER, 8'h55);
        repeat (30) @(posedge core_clk);
        rst_n <= 1'b0;
        @(posedge core_clk);
        #1 oe_chk(2'b00);
        @(posedge core_clk);
        rst_n <= 1'b1;
        rd(`OFS_CTRL_ONE);
        chk("port off", 8'h00, d);
        chk("scl high time", 8'h01, {7'h00, min_high >= 8'h0F});
        finish_test();
    end
endmodule : test_i2c_seq_master
